/* File: pmrc_core.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
// power mode and reset control: control register, idle and power-down, reset sequencing
// Notes on behaviour
// - idle halts cpu; timers, watchdog, uart, external interrupts keep running
// - setting idle is last instruction; cpu state retained through idle
// - enabled interrupt in idle clears idle bit; resume after return
// - bits 2 and 3 are free software flags
// - external reset ends idle; oscillator keeps running
// - watchdog reset ends idle
// - power-down bit halts cpu and stops oscillator, watchdog state irrelevant
// - power-down ends on reset or either external interrupt, state kept
// - after wake interrupt service, execution resumes after power-down instruction
// - strobes high in idle, low in power-down; ports hold latches unless code is external
// - external-memory power-down drives port 2 from its latch
// - control register at 87H, resets to 00H, byte access only
// - bit 7 doubles baud rate for timer 1 in serial modes 1-3
// - bit 6 disables aux ram; external moves go external
// - bit 5 stops address latch strobe toggling; cleared by reset
// - watchdog load enable set by software, cleared on watchdog load
// - power-down wins when both mode bits written together
// - reset pin high two machine cycles; strobes high during reset
// - reset pin sampled each machine cycle; reset from second high sample
// - enabled watchdog overflow forces reset regardless of pin
module pmrc_core #(
	parameter int OSC_PER_MC = pmrc_pkg::PMRC_OSC_PER_MC,
	parameter int WAKE_CYC   = pmrc_pkg::PMRC_WAKE_STABLE_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_reset_pin,
	input  wire logic       i_wake_line_a_n,
	input  wire logic       i_wake_line_b_n,
	input  wire logic       i_irq_taken,
	input  wire logic       i_wdt_overflow,
	input  wire logic       i_wdt_loaded,
	input  wire logic       i_ext_code,
	input  wire logic [7:0] i_high_address_port_latch,
	input  wire logic [7:0] i_fetch_addr_hi,
	output logic            o_cpu_run,
	output logic            o_osc_run,
	output logic            o_periph_run,
	output logic            o_core_reset,
	output logic            o_addr_latch_strobe,
	output logic            o_program_store_strobe,
	output logic      [7:0] o_port2_out,
	output logic            o_port0_float,
	output logic            o_baud_double,
	output logic            o_aux_ram_off,
	output logic            o_watchdog_load_enable,
	output logic            o_wdt_reset_en
);
	initial begin
		if (OSC_PER_MC < 2 || OSC_PER_MC > 255) $error("OSC_PER_MC out of range");
		if (WAKE_CYC < 1 || WAKE_CYC > 65535) $error("WAKE_CYC out of range");
	end

	typedef struct packed {
		logic [7:0]           power_mode_control;
		logic                 wdt_en;
		pmrc_pkg::pmrc_mode_e mode;
		logic [7:0]           phase;
		logic [1:0]           rst_seen;
		logic                 rst_active;
		logic                 wdt_rst;
		logic [15:0]          wake_cnt;
		logic                 ext_at_pd;
		logic [7:0]           rdata;
		logic                 ale;
		logic [7:0]           p2;
	} pmrc_core_s;
	pmrc_core_s st_reg;
	pmrc_core_s st_next;

	logic pin_level;
	logic wake_a_n;
	logic wake_b_n;

	// pins cross into the core clock domain
	pmrc_sync #(.INIT(1'b0)) u_sync_rst (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_reset_pin),
		.o_level   (pin_level)
	);
	pmrc_sync #(.INIT(1'b1)) u_sync_wa (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_wake_line_a_n),
		.o_level   (wake_a_n)
	);
	pmrc_sync #(.INIT(1'b1)) u_sync_wb (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_wake_line_b_n),
		.o_level   (wake_b_n)
	);

	function automatic logic mc_end(input logic [7:0] ph);
		mc_end = (ph == 8'(OSC_PER_MC - 1));
	endfunction

	logic wake_low;
	logic mc_tick;
	assign wake_low = !wake_a_n || !wake_b_n;
	assign mc_tick  = mc_end(st_reg.phase);

	// next state: register writes, mode sequencing and reset sampling
	always_comb begin
		st_next       = st_reg;
		st_next.rdata = 8'h00;
		// machine cycle phase stops while the oscillator is frozen; a high reset
		// pin restarts it, else the pin would never be sampled in power-down
		if (st_reg.mode == pmrc_pkg::PMRC_PDOWN && !pin_level) begin
			st_next.phase = 8'h00;
		end else if (mc_tick) begin
			st_next.phase = 8'h00;
		end else begin
			st_next.phase = st_reg.phase + 8'h01;
		end
		// reset pin sampled once per machine cycle, fires on second high sample
		if (mc_tick) begin
			st_next.rst_seen   = {st_reg.rst_seen[0], pin_level};
			st_next.rst_active = pin_level && st_reg.rst_seen[0];
		end
		// watchdog path is internal, independent of the pin
		st_next.wdt_rst = st_reg.wdt_en && i_wdt_overflow;
		// byte-wide register port; no single-bit access exists
		if (i_wr && i_addr == pmrc_pkg::PMRC_POWER_MODE_CONTROL_ADDR) begin
			st_next.power_mode_control = i_wdata;
			if (i_wdata[pmrc_pkg::PMRC_BIT_PDOWN]) begin
				st_next.mode      = pmrc_pkg::PMRC_PDOWN;
				st_next.ext_at_pd = i_ext_code;
				st_next.p2        = i_high_address_port_latch;
			end else if (i_wdata[pmrc_pkg::PMRC_BIT_IDLE]) begin
				st_next.mode = pmrc_pkg::PMRC_IDLE;
			end
		end else if (i_wr && i_addr == pmrc_pkg::PMRC_WDT_CTRL_ADDR) begin
			st_next.wdt_en = i_wdata[0];
		end
		// load enable drops when the watchdog is loaded; load wins over a write
		if (i_wdt_loaded) begin
			st_next.power_mode_control[pmrc_pkg::PMRC_BIT_WLE] = 1'b0;
		end
		// mode exits
		case (st_reg.mode)
			pmrc_pkg::PMRC_IDLE: begin
				if (i_irq_taken) begin
					st_next.mode = pmrc_pkg::PMRC_RUN;
					st_next.power_mode_control[pmrc_pkg::PMRC_BIT_IDLE] = 1'b0;
				end
			end
			pmrc_pkg::PMRC_PDOWN: begin
				if (wake_low) begin
					st_next.mode     = pmrc_pkg::PMRC_WAKE;
					st_next.wake_cnt = 16'(WAKE_CYC);
				end
			end
			pmrc_pkg::PMRC_WAKE: begin
				// oscillator settling; state untouched, resumes after entry point
				if (st_reg.wake_cnt <= 16'h0001) begin
					st_next.mode = pmrc_pkg::PMRC_RUN;
					st_next.power_mode_control[pmrc_pkg::PMRC_BIT_PDOWN] = 1'b0;
				end else begin
					st_next.wake_cnt = st_reg.wake_cnt - 16'h0001;
				end
			end
			default: begin
			end
		endcase
		// address latch strobe toggles twice each machine cycle unless quieted
		if (mc_end(st_reg.phase) || st_reg.phase == 8'(pmrc_pkg::PMRC_ALE_PHASE - 1)) begin
			st_next.ale = !st_reg.ale;
		end
		// read data stands the cycle after the strobe
		if (i_rd) begin
			if (i_addr == pmrc_pkg::PMRC_POWER_MODE_CONTROL_ADDR) begin
				st_next.rdata = st_reg.power_mode_control;
			end else if (i_addr == pmrc_pkg::PMRC_STATUS_ADDR) begin
				st_next.rdata = {4'h0, st_reg.rst_active, st_reg.wdt_rst, st_reg.mode};
			end else if (i_addr == pmrc_pkg::PMRC_WDT_CTRL_ADDR) begin
				st_next.rdata = {7'h00, st_reg.wdt_en};
			end else begin
				st_next.rdata = 8'h00;
			end
		end
		// any reset ends idle or power-down and clears the register
		if (st_reg.rst_active || st_reg.wdt_rst) begin
			st_next.power_mode_control   = pmrc_pkg::PMRC_POWER_MODE_CONTROL_RST;
			st_next.mode   = pmrc_pkg::PMRC_RUN;
			st_next.wdt_en = 1'b0;
		end
	end

	// single register for all state
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_reg      <= '0;
			st_reg.mode <= pmrc_pkg::PMRC_RUN;
		end else begin
			st_reg <= st_next;
		end
	end

	logic in_reset;
	logic in_idle;
	logic in_pd;
	assign in_reset = st_reg.rst_active || st_reg.wdt_rst;
	assign in_idle  = st_reg.mode == pmrc_pkg::PMRC_IDLE;
	assign in_pd    = st_reg.mode == pmrc_pkg::PMRC_PDOWN || st_reg.mode == pmrc_pkg::PMRC_WAKE;

	// cpu halts in both modes; peripherals run in idle only
	assign o_cpu_run    = st_reg.mode == pmrc_pkg::PMRC_RUN && !in_reset;
	assign o_periph_run = !in_pd;
	assign o_osc_run    = st_reg.mode != pmrc_pkg::PMRC_PDOWN;
	assign o_core_reset = in_reset;

	// pin states per mode; reset forces strobes high
	always_comb begin
		if (in_reset || in_idle) begin
			o_addr_latch_strobe    = 1'b1;
			o_program_store_strobe = 1'b1;
		end else if (in_pd) begin
			o_addr_latch_strobe    = 1'b0;
			o_program_store_strobe = 1'b0;
		end else begin
			o_addr_latch_strobe    = st_reg.ale && !st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_QUIET];
			o_program_store_strobe = 1'b1;
		end
	end

	// port 2: address in external idle, own latch in power-down
	always_comb begin
		if (in_idle && i_ext_code) begin
			o_port2_out = i_fetch_addr_hi;
		end else if (in_pd && st_reg.ext_at_pd) begin
			o_port2_out = st_reg.p2;
		end else begin
			o_port2_out = i_high_address_port_latch;
		end
	end
	assign o_port0_float = (in_idle || in_pd) && i_ext_code;

	assign o_rdata                = st_reg.rdata;
	assign o_baud_double          = st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_BAUD2];
	assign o_aux_ram_off          = st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_AUXOFF];
	assign o_watchdog_load_enable = st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_WLE];
	assign o_wdt_reset_en         = st_reg.wdt_en;

	sequence s_pd_write;
		i_wr && i_addr == pmrc_pkg::PMRC_POWER_MODE_CONTROL_ADDR
			&& i_wdata[pmrc_pkg::PMRC_BIT_PDOWN];
	endsequence
	sequence s_no_reset;
		!st_reg.rst_active && !st_reg.wdt_rst;
	endsequence

	a_pd_precedence: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_pd_write and s_no_reset |=> st_reg.mode == pmrc_pkg::PMRC_PDOWN)
		else $error("power-down did not win");
	a_idle_exit_irq: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_idle && i_irq_taken && !i_wr |=> !st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_IDLE] && o_cpu_run
			|| in_reset)
		else $error("idle not ended by interrupt");
	a_idle_strobes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_idle |-> o_addr_latch_strobe && o_program_store_strobe && o_periph_run && !o_cpu_run)
		else $error("idle pin state wrong");
	a_pd_strobes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_pd && !in_reset |-> !o_addr_latch_strobe && !o_program_store_strobe)
		else $error("power-down strobes not low");
	a_reset_strobes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_core_reset |-> o_addr_latch_strobe && o_program_store_strobe && !o_cpu_run)
		else $error("strobes not high in reset");
	a_wdt_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_reg.wdt_en && i_wdt_overflow |=> o_core_reset ##1 st_reg.power_mode_control == 8'h00)
		else $error("watchdog overflow did not reset");
	a_wle_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_wdt_loaded |=> !o_watchdog_load_enable)
		else $error("load enable not cleared");
	a_power_mode_control_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_rd && i_addr == pmrc_pkg::PMRC_POWER_MODE_CONTROL_ADDR |=> o_rdata == $past(st_reg.power_mode_control))
		else $error("control register read wrong");
	a_quiet_strobe: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_QUIET] && o_cpu_run |-> !o_addr_latch_strobe)
		else $error("strobe toggles while quiet");
	a_pd_port2: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_pd && st_reg.ext_at_pd |-> o_port2_out == st_reg.p2 && o_port0_float)
		else $error("port 2 not held in power-down");
	a_reset_sample: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		mc_tick && pin_level && st_reg.rst_seen[0] |=> st_reg.rst_active)
		else $error("reset not taken on second sample");

	// power-down with no wake line and no reset pin: nothing may move
	sequence s_pd_quiet;
		st_reg.mode == pmrc_pkg::PMRC_PDOWN && !wake_low && !pin_level && !i_wr;
	endsequence

	// entry, hold, wake and resume of power-down
	a_pd_entry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_pd_write and s_no_reset |=> !o_osc_run && !o_cpu_run)
		else $error("power-down entry did not stop oscillator");
	a_pd_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_pd_quiet and s_no_reset |=> st_reg.mode == pmrc_pkg::PMRC_PDOWN && !o_osc_run
			&& st_reg.phase == 8'h00)
		else $error("power-down left without cause");
	a_pd_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_no_reset and (st_reg.mode == pmrc_pkg::PMRC_PDOWN && wake_low)
			|=> st_reg.mode == pmrc_pkg::PMRC_WAKE && o_osc_run && !o_cpu_run)
		else $error("wake line did not restart oscillator");
	a_wake_resume: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_no_reset and (st_reg.mode == pmrc_pkg::PMRC_WAKE && st_reg.wake_cnt <= 16'h0001)
			|=> st_reg.mode == pmrc_pkg::PMRC_RUN && !st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_PDOWN])
		else $error("wake did not resume execution");
	a_periph_pd: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_pd |-> !o_periph_run && !o_cpu_run)
		else $error("core or peripherals run in power-down");

	// reset sequencing: clears, repeats while the pin is high, ends when low
	a_reset_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_reset |=> st_reg.mode == pmrc_pkg::PMRC_RUN && !st_reg.wdt_en
			&& st_reg.power_mode_control == pmrc_pkg::PMRC_POWER_MODE_CONTROL_RST)
		else $error("reset did not clear mode and register");
	a_reset_repeat: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		st_reg.rst_active && !mc_tick |=> st_reg.rst_active)
		else $error("reset dropped between samples");
	a_reset_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		mc_tick && !pin_level |=> !st_reg.rst_active)
		else $error("reset held after pin went low");
	a_wdt_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!st_reg.wdt_en |=> !st_reg.wdt_rst)
		else $error("watchdog reset while disabled");

	// software flags and idle port state
	a_flags_free: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_wr && i_addr == pmrc_pkg::PMRC_POWER_MODE_CONTROL_ADDR && !in_reset
			|=> st_reg.power_mode_control[pmrc_pkg::PMRC_BIT_FLAG_B:pmrc_pkg::PMRC_BIT_FLAG_A]
			== $past(i_wdata[pmrc_pkg::PMRC_BIT_FLAG_B:pmrc_pkg::PMRC_BIT_FLAG_A]))
		else $error("general flags not written");
	a_idle_port2: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		in_idle && i_ext_code |-> o_port2_out == i_fetch_addr_hi && o_port0_float)
		else $error("idle external port state wrong");
endmodule

/* File: pmrc_core_tb.sv */
// self-checking bench for power mode and reset control
`timescale 1ns/100ps
module pmrc_core_tb;
	logic       clk      = 1'b0;
	logic       rst_n    = 1'b0;
	logic [7:0] addr     = 8'h00;
	logic [7:0] wdata    = 8'h00;
	logic       wr       = 1'b0;
	logic       rd       = 1'b0;
	logic       rst_req  = 1'b0;
	logic [1:0] wake_req = 2'b00;
	logic       irq      = 1'b0;
	logic       wovf     = 1'b0;
	logic       wld      = 1'b0;
	logic       ext      = 1'b0;
	logic [7:0] latch    = 8'hA5;
	logic [7:0] fetch    = 8'h3C;
	logic [7:0] rdata, p2, rv;
	logic       pin, wa_n, wb_n, cpu, osc, per, crst, ale, pse, p0f, bd, aux, watchdog_load_enable, wen;
	int         mismatches   = 0;
	int         total_checks = 0;
	int         n;

	pmrc_far_side i_far (.i_core_clk(clk), .i_rst_req(rst_req), .i_wake_req(wake_req),
		.o_reset_pin(pin), .o_wake_a_n(wa_n), .o_wake_b_n(wb_n));

	// short settle count keeps the wake runs brief
	pmrc_core #(.WAKE_CYC(4)) i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_reset_pin(pin),
		.i_wake_line_a_n(wa_n), .i_wake_line_b_n(wb_n), .i_irq_taken(irq),
		.i_wdt_overflow(wovf), .i_wdt_loaded(wld), .i_ext_code(ext),
		.i_high_address_port_latch(latch), .i_fetch_addr_hi(fetch), .o_cpu_run(cpu),
		.o_osc_run(osc), .o_periph_run(per), .o_core_reset(crst),
		.o_addr_latch_strobe(ale), .o_program_store_strobe(pse), .o_port2_out(p2),
		.o_port0_float(p0f), .o_baud_double(bd), .o_aux_ram_off(aux),
		.o_watchdog_load_enable(watchdog_load_enable), .o_wdt_reset_en(wen));

	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	// one-cycle write; the trailing delay lets the new state land
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
		chk(rv, exp);
	endtask

	// bounded wait for a level, cycles counted in cyc
	task automatic wait_for(ref logic s, input logic v, input int lim, output int cyc);
		cyc = 0;
		while (s !== v && cyc < lim) begin
			@(posedge clk);
			#1 cyc++;
		end
	endtask

	task automatic pin_reset();
		@(posedge clk);
		rst_req <= 1'b1;
		wait_for(crst, 1'b1, 60, n);
		chkb(n >= 12 && n <= 40, 1'b1);
		chkb(ale, 1'b1);
		chkb(pse, 1'b1);
		repeat (30) @(posedge clk);
		#1 chkb(crst, 1'b1);
		rst_req <= 1'b0;
		wait_for(crst, 1'b0, 60, n);
		chkb(cpu, 1'b1);
		rchk(8'h87, 8'h00);
		rchk(8'h88, 8'h00);
	endtask

	task automatic t_regs();
		rchk(8'h87, 8'h00);
		rchk(8'hFF, 8'h00);
		wr_reg(8'h87, 8'hCC);
		rchk(8'h87, 8'hCC);
		chkb(bd, 1'b1);
		chkb(aux, 1'b1);
		wr_reg(8'h87, 8'h00);
		chkb(bd, 1'b0);
	endtask

	task automatic t_idle();
		@(posedge clk);
		ext <= 1'b1;
		wr_reg(8'h87, 8'h05);
		chkb(cpu, 1'b0);
		chkb(per, 1'b1);
		chkb(ale & pse, 1'b1);
		chk(p2, fetch);
		chkb(p0f, 1'b1);
		rchk(8'h88, 8'h01);
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		#1 chkb(cpu, 1'b1);
		rchk(8'h87, 8'h04);
	endtask

	// a pin pulse shorter than one machine cycle must not reset
	task automatic t_short_pin();
		@(posedge clk);
		rst_req <= 1'b1;
		repeat (6) @(posedge clk);
		rst_req <= 1'b0;
		wait_for(crst, 1'b1, 40, n);
		chkb(crst, 1'b0);
		wr_reg(8'h87, 8'h01);
		pin_reset();
	endtask

	task automatic t_pd_prec();
		wr_reg(8'h87, 8'h03);
		rchk(8'h88, 8'h02);
		chkb(wen | osc | cpu, 1'b0);
		chkb(ale | pse, 1'b0);
		chk(p2, latch);
		pin_reset();
	endtask

	task automatic t_wake();
		for (int i = 0; i < 2; i++) begin
			wr_reg(8'h87, 8'h0A);
			// stay down a while so a stale line cannot fake the wake
			repeat (8) @(posedge clk);
			#1 chkb(osc | cpu, 1'b0);
			// only this wake line is driven here; either line alone ends power-down
			wake_req[i] <= 1'b1;
			wait_for(cpu, 1'b1, 60, n);
			chkb(cpu & osc & (n >= 4), 1'b1);
			chk(p2, latch);
			wake_req <= 2'b00;
			// let the released line pass the synchroniser before the next entry
			repeat (8) @(posedge clk);
			rchk(8'h87, 8'h08);
		end
	endtask

	task automatic t_wdt();
		@(posedge clk);
		wovf <= 1'b1;
		@(posedge clk);
		wovf <= 1'b0;
		wait_for(crst, 1'b1, 20, n);
		chkb(crst, 1'b0);
		wr_reg(8'h89, 8'h01);
		chkb(wen, 1'b1);
		wr_reg(8'h87, 8'h01);
		wovf <= 1'b1;
		@(posedge clk);
		wovf <= 1'b0;
		// watchdog reset stands one cycle only, so look right after the edge
		#1 chkb(crst, 1'b1);
		chkb(ale & pse, 1'b1);
		wait_for(crst, 1'b0, 60, n);
		chkb(cpu, 1'b1);
		rchk(8'h87, 8'h00);
		chkb(wen, 1'b0);
	endtask

	task automatic t_wle();
		wr_reg(8'h87, 8'h10);
		chkb(watchdog_load_enable, 1'b1);
		wld <= 1'b1;
		@(posedge clk);
		wld <= 1'b0;
		rchk(8'h87, 8'h00);
		chkb(watchdog_load_enable, 1'b0);
	endtask

	// address strobe edges over two machine cycles, then quiet, then reset clears it
	task automatic count_ale(output int t);
		logic last;
		t    = 0;
		last = ale;
		repeat (24) begin
			@(posedge clk);
			#1 t += (ale !== last);
			last = ale;
		end
	endtask

	task automatic t_strobe_quiet();
		int t;
		count_ale(t);
		chkb(t > 0, 1'b1);
		wr_reg(8'h87, 8'h20);
		count_ale(t);
		chkb(t == 0, 1'b1);
		pin_reset();
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		$display("MISMATCH at %0t: timeout", $time);
		finish_test();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_idle();
		t_short_pin();
		t_pd_prec();
		t_wake();
		t_wdt();
		t_wle();
		t_strobe_quiet();
		finish_test();
	end
endmodule

/* File: pmrc_far_side.sv */
// far-side model: external reset source and two wake lines
`timescale 1ns/100ps
module pmrc_far_side (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_req,
	input  wire logic [1:0] i_wake_req,
	output logic            o_reset_pin = 1'b0,
	output logic            o_wake_a_n  = 1'b1,
	output logic            o_wake_b_n  = 1'b1
);
	// pins move only after an edge; wake lines idle high like a pulled-up line
	always_ff @(posedge i_core_clk) begin
		o_reset_pin <= i_rst_req;
		o_wake_a_n  <= ~i_wake_req[0];
		o_wake_b_n  <= ~i_wake_req[1];
	end
endmodule

/* File: pmrc_pkg.sv */
// package: register map, field positions and timing for power mode and reset control
package pmrc_pkg;
	localparam logic [7:0] PMRC_POWER_MODE_CONTROL_ADDR = 8'h87;
	localparam logic [7:0] PMRC_POWER_MODE_CONTROL_RST  = 8'h00;
	localparam logic [7:0] PMRC_STATUS_ADDR             = 8'h88;
	localparam logic [7:0] PMRC_WDT_CTRL_ADDR           = 8'h89;
	localparam int         PMRC_BIT_IDLE                = 0;
	localparam int         PMRC_BIT_PDOWN               = 1;
	localparam int         PMRC_BIT_FLAG_A              = 2;
	localparam int         PMRC_BIT_FLAG_B              = 3;
	localparam int         PMRC_BIT_WLE                 = 4;
	localparam int         PMRC_BIT_QUIET               = 5;
	localparam int         PMRC_BIT_AUXOFF              = 6;
	localparam int         PMRC_BIT_BAUD2               = 7;
	localparam int         PMRC_OSC_PER_MC              = 12;
	localparam int         PMRC_OSC_NS                  = 20;
	localparam int         PMRC_WAKE_STABLE_NS          = 10000;
	localparam int         PMRC_WAKE_STABLE_CYC         =
		(PMRC_WAKE_STABLE_NS + PMRC_OSC_NS - 1) / PMRC_OSC_NS;
	localparam int         PMRC_ALE_PHASE               = 6;
	typedef enum logic [1:0] {
		PMRC_RUN,
		PMRC_IDLE,
		PMRC_PDOWN,
		PMRC_WAKE
	} pmrc_mode_e;
endpackage

/* File: pmrc_sync.sv */
`timescale 1ns/100ps
// three-stage pin synchroniser, change accepted when stages two and three agree
module pmrc_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_pin,
	output logic      o_level
);
	typedef struct packed {
		logic [2:0] stg;
		logic       lvl;
	} pmrc_sync_s;
	pmrc_sync_s st_reg;
	pmrc_sync_s st_next;

	// stage one feeds stage two only
	always_comb begin
		st_next     = st_reg;
		st_next.stg = {st_reg.stg[1:0], i_pin};
		if (st_reg.stg[1] == st_reg.stg[2]) begin
			st_next.lvl = st_reg.stg[2];
		end
	end

	// synchronous reset to the idle level
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_reg <= '{stg: {3{INIT}}, lvl: INIT};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.lvl;
endmodule
